// ---- include/mtr_cfg.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH

// ***********************************************************************
// Register offsets
// ***********************************************************************
`define MTR_OFS_SLOT_END        8'h13
`define MTR_OFS_TICK_LOW        8'h14
`define MTR_OFS_TICK_HIGH       8'h15
`define MTR_OFS_AMP_LOW         8'h16
`define MTR_OFS_AMP_HIGH        8'h17
`define MTR_OFS_AMP_CTRL        8'h18
`define MTR_OFS_BEACON_CTRL     8'h1a
`define MTR_OFS_NORMAL_CTRL     8'h1b

// ***********************************************************************
// Field positions
// ***********************************************************************
`define MTR_FIRST_SLOT_HI       7
`define MTR_FIRST_SLOT_LO       4
`define MTR_CONT_END_HI         3
`define MTR_CONT_END_LO         0
`define MTR_TICK_MSB_POS        0
`define MTR_TX_LEAD_LOW_HI      7
`define MTR_TX_LEAD_LOW_LO      1
`define MTR_TX_LEAD_TOP_HI      1
`define MTR_TX_LEAD_TOP_LO      0
`define MTR_AMP_MSB_POS         0
`define MTR_AMP_SYM_HI          4
`define MTR_AMP_SYM_LO          1
`define MTR_TRIG_POS            0
`define MTR_SEC_POS             1
`define MTR_ACK_REQ_POS         2
`define MTR_INDIRECT_POS        3
`define MTR_PENDING_POS         4

// ***********************************************************************
// Reset values
// ***********************************************************************
`define MTR_RST_SLOT            4'h0
`define MTR_RST_TICK            9'h140
`define MTR_RST_TX_LEAD         9'h028
`define MTR_RST_AMP_LEAD        9'h029
`define MTR_RST_AMP_SYM         4'h1

// ***********************************************************************
// Timing
// ***********************************************************************
`define MTR_TICK_NS             50
`define MTR_CLK_NS              25
`define MTR_TICK_CYC            ((`MTR_TICK_NS + `MTR_CLK_NS - 1) / `MTR_CLK_NS)

`endif

// ---- include/mtr_pkg.sv ----
// Types shared by the transmit timing register bank
package mtr_pkg;

   typedef logic [7:0] mtr_byte_t;

   typedef enum logic [1:0] {
      MTR_IDLE = 2'b01,
      MTR_LEAD = 2'b10
   } mtr_state_t;

endpackage : mtr_pkg

// ---- core/mtr_regs.sv ----
// Transmit timing and FIFO trigger register bank with lead sequencer
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "mtr_cfg.svh"

// Behaviour
// RL1 - First slot end nibble, bits 7-4, reset 0
// RL2 - Contention end nibble, bits 3-0, reset 0
// RL3 - Symbol period counted in 50 ns ticks
// RL4 - Nine-bit tick count, reset 0x140
// RL5 - Nine-bit transmitter lead ticks, reset 0x028
// RL6 - Nine-bit amplifier lead ticks, reset 0x029
// RL7 - Amplifier lead symbols bits 4-1, reset 1
// RL8 - Software writes zero to reserved bits
// RL9 - Beacon security option bit 1, reset off
// RL10 - Beacon trigger starts beacon, self-clearing
// RL11 - Normal trigger starts normal frame, self-clearing
// RL12 - Read-only bit 4 shows last ack pending
// RL13 - Bit 3 enables indirect transmission
// RL14 - Bit 2 requests acknowledgement with retry
// RL15 - Bit 1 enables normal frame security
// RL16 - Normal options cleared at next trigger
// RL17 - Trigger bits read zero, zero write ignored
module mtr_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RSTN,
   input  wire logic              CE,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire mtr_pkg::mtr_byte_t WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output mtr_pkg::mtr_byte_t     RDATA,
   input  wire logic              ACK_RX_VALID,
   input  wire logic              ACK_RX_PENDING,
   output logic [3:0]             FIRST_SLOT_END,
   output logic [3:0]             CONTENTION_PERIOD_END,
   output logic                   SYMBOL_STROBE,
   output logic                   BUSY,
   output logic                   TX_ON,
   output logic                   AMP_ON,
   output logic                   FRAME_START,
   output logic                   FRAME_IS_BEACON,
   output logic                   FRAME_SECURITY,
   output logic                   FRAME_ACK_REQUEST,
   output logic                   FRAME_INDIRECT
);
   import mtr_pkg::*;

   localparam int TICK_CYC = `MTR_TICK_CYC;
   localparam int DIV_W    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam int LEAD_W   = 14;

   // ***********************************************************************
   // Elaboration checks
   // ***********************************************************************
   if (ADDR_W < 5) begin : g_bad_addr
      $error("ADDR_W too small for register map");
   end

   // A tick of part clocks would drift against the symbol timing
   if (`MTR_TICK_NS % `MTR_CLK_NS != 0) begin : g_bad_tick
      $error("Tick period is not a whole number of clocks");
   end

   // Longest lead: fifteen symbols of 511 ticks plus 511 ticks
   if (LEAD_W < $clog2(16 * 512)) begin : g_bad_lead
      $error("LEAD_W too narrow for the longest lead");
   end

   // ***********************************************************************
   // Register storage
   // ***********************************************************************
   logic [3:0]        first_slot_end_q;
   logic [3:0]        contention_period_end_q;
   logic [8:0]        symbol_tick_count_q;
   logic [8:0]        tx_lead_ticks_q;
   logic [8:0]        amp_lead_ticks_q;
   logic [3:0]        amp_lead_symbols_q;
   logic              beacon_security_on_q;
   logic              normal_indirect_q;
   logic              normal_ack_request_q;
   logic              normal_security_on_q;
   logic              ack_pending_flag_q;
   mtr_byte_t         rdata_q;

   logic              wr_en;
   logic              rd_en;
   logic              beacon_send_trigger;
   logic              normal_send_trigger;
   logic              start;

   assign wr_en = CE & WR;
   assign rd_en = CE & RD;

   // Trigger bits are not stored; a one pulses the sequencer
   assign beacon_send_trigger = wr_en && (ADDR == ADDR_W'(`MTR_OFS_BEACON_CTRL))
                                && WDATA[`MTR_TRIG_POS];   // see RL10
   assign normal_send_trigger = wr_en && (ADDR == ADDR_W'(`MTR_OFS_NORMAL_CTRL))
                                && WDATA[`MTR_TRIG_POS];   // see RL11

   // ***********************************************************************
   // Slot boundaries
   // ***********************************************************************
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         first_slot_end_q        <= `MTR_RST_SLOT;
         contention_period_end_q <= `MTR_RST_SLOT;
      end else if (wr_en && ADDR == ADDR_W'(`MTR_OFS_SLOT_END)) begin
         // Both slot ends load from one write
         first_slot_end_q        <= WDATA[`MTR_FIRST_SLOT_HI:`MTR_FIRST_SLOT_LO]; // see RL1
         contention_period_end_q <= WDATA[`MTR_CONT_END_HI:`MTR_CONT_END_LO];     // see RL2
      end
   end

   // ***********************************************************************
   // Symbol tick count and transmitter lead
   // ***********************************************************************
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         symbol_tick_count_q <= `MTR_RST_TICK;      // see RL4
         tx_lead_ticks_q     <= `MTR_RST_TX_LEAD;   // see RL5
      end else if (wr_en) begin
         // Each byte of a split field is written on its own
         if (ADDR == ADDR_W'(`MTR_OFS_TICK_LOW)) begin
            symbol_tick_count_q[7:0] <= WDATA;      // see RL4
         end
         if (ADDR == ADDR_W'(`MTR_OFS_TICK_HIGH)) begin
            symbol_tick_count_q[8]   <= WDATA[`MTR_TICK_MSB_POS];
            tx_lead_ticks_q[6:0]     <= WDATA[`MTR_TX_LEAD_LOW_HI:`MTR_TX_LEAD_LOW_LO]; // see RL5
         end
         if (ADDR == ADDR_W'(`MTR_OFS_AMP_CTRL)) begin
            tx_lead_ticks_q[8:7]     <= WDATA[`MTR_TX_LEAD_TOP_HI:`MTR_TX_LEAD_TOP_LO]; // see RL5
         end
      end
   end

   // ***********************************************************************
   // Amplifier lead
   // ***********************************************************************
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         amp_lead_ticks_q   <= `MTR_RST_AMP_LEAD;   // see RL6
         amp_lead_symbols_q <= `MTR_RST_AMP_SYM;    // see RL7
      end else if (wr_en) begin
         if (ADDR == ADDR_W'(`MTR_OFS_AMP_LOW)) begin
            amp_lead_ticks_q[7:0] <= WDATA;         // see RL6
         end
         if (ADDR == ADDR_W'(`MTR_OFS_AMP_HIGH)) begin
            amp_lead_ticks_q[8] <= WDATA[`MTR_AMP_MSB_POS];
            amp_lead_symbols_q  <= WDATA[`MTR_AMP_SYM_HI:`MTR_AMP_SYM_LO]; // see RL7
         end
      end
   end

   // ***********************************************************************
   // FIFO options
   // ***********************************************************************
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         beacon_security_on_q <= 1'b0;
      end else if (wr_en && ADDR == ADDR_W'(`MTR_OFS_BEACON_CTRL)) begin
         // The beacon option survives a trigger, unlike the normal ones
         beacon_security_on_q <= WDATA[`MTR_SEC_POS];   // see RL9
      end
   end

   // A normal trigger write consumes the options it carries, so they read back clear
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         normal_indirect_q    <= 1'b0;
         normal_ack_request_q <= 1'b0;
         normal_security_on_q <= 1'b0;
      end else if (normal_send_trigger) begin
         normal_indirect_q    <= 1'b0;                  // see RL16
         normal_ack_request_q <= 1'b0;
         normal_security_on_q <= 1'b0;
      end else if (wr_en && ADDR == ADDR_W'(`MTR_OFS_NORMAL_CTRL)) begin
         normal_indirect_q    <= WDATA[`MTR_INDIRECT_POS];  // see RL13
         normal_ack_request_q <= WDATA[`MTR_ACK_REQ_POS];   // see RL14
         normal_security_on_q <= WDATA[`MTR_SEC_POS];       // see RL15
      end
   end

   // Pending status follows each received acknowledgement
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ack_pending_flag_q <= 1'b0;
      end else if (CE && ACK_RX_VALID) begin
         ack_pending_flag_q <= ACK_RX_PENDING;          // see RL12
      end
   end

   // ***********************************************************************
   // Read port
   // ***********************************************************************
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rdata_q <= 8'h00;
      end else if (CE) begin
         rdata_q <= 8'h00;
         // Read data stand one cycle, then fall back to zero
         if (rd_en) begin
            unique case (ADDR)
               ADDR_W'(`MTR_OFS_SLOT_END): begin
                  rdata_q <= {first_slot_end_q, contention_period_end_q};
               end
               ADDR_W'(`MTR_OFS_TICK_LOW): begin
                  rdata_q <= symbol_tick_count_q[7:0];
               end
               ADDR_W'(`MTR_OFS_TICK_HIGH): begin
                  rdata_q <= {tx_lead_ticks_q[6:0], symbol_tick_count_q[8]};
               end
               ADDR_W'(`MTR_OFS_AMP_LOW): begin
                  rdata_q <= amp_lead_ticks_q[7:0];
               end
               ADDR_W'(`MTR_OFS_AMP_HIGH): begin
                  rdata_q <= {3'h0, amp_lead_symbols_q, amp_lead_ticks_q[8]};
               end
               ADDR_W'(`MTR_OFS_AMP_CTRL): begin
                  rdata_q <= {6'h00, tx_lead_ticks_q[8:7]};
               end
               ADDR_W'(`MTR_OFS_BEACON_CTRL): begin
                  rdata_q <= {6'h00, beacon_security_on_q, 1'b0};   // see RL17
               end
               ADDR_W'(`MTR_OFS_NORMAL_CTRL): begin
                  rdata_q <= {3'h0, ack_pending_flag_q, normal_indirect_q,
                              normal_ack_request_q, normal_security_on_q, 1'b0}; // see RL17
               end
               default: begin
                  rdata_q <= 8'h00;
               end
            endcase
         end
      end
   end

   assign RDATA                 = rdata_q;
   assign FIRST_SLOT_END        = first_slot_end_q;
   assign CONTENTION_PERIOD_END = contention_period_end_q;

   // ***********************************************************************
   // Tick divider and symbol strobe
   // ***********************************************************************
   logic [DIV_W-1:0] div_q;
   logic             tick_en;
   logic [8:0]       sym_cnt_q;
   logic             sym_strobe_q;

   // The divider freezes with CE, so ticks never shorten
   assign tick_en = CE && (div_q == DIV_W'(TICK_CYC - 1));   // see RL3

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         div_q <= '0;
      end else if (CE) begin
         if (tick_en) begin
            div_q <= '0;
         end else begin
            div_q <= div_q + DIV_W'(1);
         end
      end
   end

   // A count of zero stops the symbol strobe
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sym_cnt_q    <= 9'h000;
         sym_strobe_q <= 1'b0;
      end else if (CE) begin
         sym_strobe_q <= 1'b0;
         if (tick_en) begin
            if (symbol_tick_count_q != 9'h000 && sym_cnt_q >= symbol_tick_count_q - 9'h001) begin
               sym_cnt_q    <= 9'h000;
               sym_strobe_q <= 1'b1;                    // see RL4
            end else begin
               sym_cnt_q <= sym_cnt_q + 9'h001;
            end
         end
      end
   end

   assign SYMBOL_STROBE = sym_strobe_q;

   // ***********************************************************************
   // Lead sequencer
   // ***********************************************************************
   mtr_state_t        state_q;
   logic [LEAD_W-1:0] lead_q;
   logic [LEAD_W-1:0] lead_total;
   logic              frame_start_q;
   logic              frame_beacon_q;
   logic              frame_sec_q;
   logic              frame_ack_q;
   logic              frame_ind_q;

   // Total amplifier lead in ticks: whole symbols plus extra ticks
   assign lead_total = LEAD_W'(amp_lead_symbols_q) * LEAD_W'(symbol_tick_count_q)
                       + LEAD_W'(amp_lead_ticks_q);     // see RL6 see RL7

   // Triggers while a frame is being led in are dropped
   // Lead counts down once a tick; the frame starts one tick after zero
   assign start = (state_q == MTR_IDLE) && (beacon_send_trigger || normal_send_trigger);

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state_q       <= MTR_IDLE;
         lead_q        <= '0;
         frame_start_q <= 1'b0;
      end else if (CE) begin
         frame_start_q <= 1'b0;
         unique case (state_q)
            MTR_IDLE: begin
               if (start) begin
                  lead_q  <= lead_total;
                  state_q <= MTR_LEAD;
               end
            end
            MTR_LEAD: begin
               if (tick_en) begin
                  if (lead_q == '0) begin
                     frame_start_q <= 1'b1;             // see RL10 see RL11
                     state_q       <= MTR_IDLE;
                  end else begin
                     lead_q <= lead_q - LEAD_W'(1);
                  end
               end
            end
            // An unused state code falls back to idle
            default: begin
               state_q <= MTR_IDLE;
            end
         endcase
      end
   end

   // Frame descriptor captured at the trigger; beacon wins a same-cycle tie
   // The descriptor stands until the next accepted trigger
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         frame_beacon_q <= 1'b0;
         frame_sec_q    <= 1'b0;
         frame_ack_q    <= 1'b0;
         frame_ind_q    <= 1'b0;
      end else if (CE && start) begin
         if (beacon_send_trigger) begin
            frame_beacon_q <= 1'b1;
            frame_sec_q    <= WDATA[`MTR_SEC_POS];      // see RL9
            frame_ack_q    <= 1'b0;
            frame_ind_q    <= 1'b0;
         end else begin
            frame_beacon_q <= 1'b0;
            frame_sec_q    <= WDATA[`MTR_SEC_POS];      // see RL15
            frame_ack_q    <= WDATA[`MTR_ACK_REQ_POS];  // see RL14
            frame_ind_q    <= WDATA[`MTR_INDIRECT_POS]; // see RL13
         end
      end
   end

   // The transmitter joins once the remaining lead fits its own lead
   assign BUSY              = (state_q == MTR_LEAD);
   assign AMP_ON            = (state_q == MTR_LEAD);                            // see RL6
   assign TX_ON             = (state_q == MTR_LEAD)
                              && (lead_q <= LEAD_W'(tx_lead_ticks_q));           // see RL5
   assign FRAME_START       = frame_start_q;
   assign FRAME_IS_BEACON   = frame_beacon_q;
   assign FRAME_SECURITY    = frame_sec_q;
   assign FRAME_ACK_REQUEST = frame_ack_q;
   assign FRAME_INDIRECT    = frame_ind_q;

endmodule : mtr_regs

// ---- dv/mtr_regs_chk.sv ----
// Port assertions for the transmit timing register bank
`timescale 1ns/10ps
`include "mtr_cfg.svh"
module mtr_regs_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic               CLK_SYS,
   input wire logic               RSTN,
   input wire logic               CE,
   input wire logic [ADDR_W-1:0]  ADDR,
   input wire mtr_pkg::mtr_byte_t WDATA,
   input wire logic               WR,
   input wire logic               RD,
   input wire mtr_pkg::mtr_byte_t RDATA,
   input wire logic               ACK_RX_VALID,
   input wire logic               ACK_RX_PENDING,
   input wire logic [3:0]         FIRST_SLOT_END,
   input wire logic [3:0]         CONTENTION_PERIOD_END,
   input wire logic               SYMBOL_STROBE,
   input wire logic               BUSY,
   input wire logic               TX_ON,
   input wire logic               AMP_ON,
   input wire logic               FRAME_START,
   input wire logic               FRAME_IS_BEACON,
   input wire logic               FRAME_SECURITY,
   input wire logic               FRAME_ACK_REQUEST,
   input wire logic               FRAME_INDIRECT
);
   import mtr_pkg::*;
   // *****************
   // Trigger decode
   // *****************
   logic go_n;
   logic go_b;
   assign go_n = CE && WR && ADDR == ADDR_W'(`MTR_OFS_NORMAL_CTRL) && WDATA[0];
   assign go_b = CE && WR && ADDR == ADDR_W'(`MTR_OFS_BEACON_CTRL) && WDATA[0];

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);

   slot_load_a:
      assert property (CE && WR && ADDR == ADDR_W'(`MTR_OFS_SLOT_END)
         |=> {FIRST_SLOT_END, CONTENTION_PERIOD_END} == $past(WDATA)) else $error("slot ends");
   trig_reads_zero_a:
      assert property (CE && RD && (ADDR == ADDR_W'(`MTR_OFS_NORMAL_CTRL)
         || ADDR == ADDR_W'(`MTR_OFS_BEACON_CTRL)) |=> !RDATA[0]) else $error("trigger reads 1");
   normal_start_a:
      assert property (go_n && !BUSY |=> BUSY && !FRAME_IS_BEACON
         && {FRAME_INDIRECT, FRAME_ACK_REQUEST, FRAME_SECURITY} == $past(WDATA[3:1]))
      else $error("normal start");
   beacon_start_a:
      assert property (go_b && !BUSY |=> BUSY && FRAME_IS_BEACON) else $error("beacon start");
   busy_drop_a:
      assert property ((go_n || go_b) && BUSY |=> $stable(FRAME_IS_BEACON)
         && $stable(FRAME_SECURITY)) else $error("trigger taken while busy");
   amp_lead_a:
      assert property (AMP_ON == BUSY && (!$rose(AMP_ON) || $past(go_n || go_b)))
      else $error("amplifier not over lead");
   idle_hold_a:
      assert property (!BUSY && !go_n && !go_b |=> !BUSY) else $error("start without trigger");
   frame_end_a:
      assert property ($rose(FRAME_START) |-> !BUSY && $past(TX_ON)) else $error("frame end");
   strobe_pulse_a:
      assert property (CE && SYMBOL_STROBE |=> !SYMBOL_STROBE) else $error("strobe width");
   freeze_hold_a:
      assert property (!CE |=> $stable(FIRST_SLOT_END) && $stable(RDATA) && $stable(BUSY))
      else $error("state moved while frozen");
endmodule : mtr_regs_chk

// ---- dv/mtr_regs_tb.sv ----
// Self-checking testbench of the transmit timing register bank
`timescale 1ns/10ps
module testbench;
   import mtr_pkg::*;
   localparam logic [7:0] WM [19:27] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h03, 8'h00,
                                         8'h02, 8'h0e};
   localparam logic [8:0] TK0 = 9'h140;
   localparam logic [8:0] TX0 = 9'h028;
   localparam logic [8:0] AM0 = 9'h029;
   logic       clk_sys, rstn, ce, wr_stb, rd_stb, ack_valid, ack_pending;
   logic       sym, busy, tx_on, amp_on, fstart, f_bcn, f_sec, f_ack, f_ind;
   logic [7:0] addr;
   logic [3:0] first_end, cont_end;
   mtr_byte_t  wdata, rdata;
   logic [7:0] m [19:27];
   int         miscompares, checked, n, t_tx;

   mtr_regs i_dut (
      .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
      .RD(rd_stb), .RDATA(rdata), .ACK_RX_VALID(ack_valid), .ACK_RX_PENDING(ack_pending),
      .FIRST_SLOT_END(first_end), .CONTENTION_PERIOD_END(cont_end), .SYMBOL_STROBE(sym),
      .BUSY(busy), .TX_ON(tx_on), .AMP_ON(amp_on), .FRAME_START(fstart),
      .FRAME_IS_BEACON(f_bcn), .FRAME_SECURITY(f_sec), .FRAME_ACK_REQUEST(f_ack),
      .FRAME_INDIRECT(f_ind)
   );

   // *****************
   // Bus tasks
   // *****************
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      if (ce === 1'b1 && a >= 8'h13 && a <= 8'h1b) begin
         m[a] = (d & WM[a]) | (m[a] & ~WM[a]);
         if (a == 8'h1b && d[0]) m[a][3:1] = 3'b000;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      check(rdata, (a >= 8'h13 && a <= 8'h1b) ? m[a] : 8'h00, "read");
   endtask : rd

   task automatic read_all();
      for (int a = 18; a <= 28; a++) rd(8'(a));
      check({first_end, cont_end}, m[19], "slot ports");
   endtask : read_all

   task automatic ack_rx(input logic p);
      @(posedge clk_sys);
      ack_valid   <= 1'b1;
      ack_pending <= p;
      @(posedge clk_sys);
      ack_valid   <= 1'b0;
      m[27][4] = p;
      rd(8'h1b);
   endtask : ack_rx

   task automatic wait_start(input int n0, input int lead, input int txl);
      n    = n0;
      t_tx = -1;
      #1;
      while (fstart !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (tx_on === 1'b1 && t_tx < 0) t_tx = n;
      end
      check(8'(n >= 2 * lead && n <= 2 * lead + 3), 8'h01, "lead span");
      check(8'(n - t_tx >= 2 * txl - 2 && n - t_tx <= 2 * txl + 4), 8'h01, "tx span");
   endtask : wait_start

   task automatic do_reset();
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      m = '{8'h00, TK0[7:0], {TX0[6:0], TK0[8]}, AM0[7:0], {3'b000, 4'h1, AM0[8]},
            {6'h00, TX0[8:7]}, 8'h00, 8'h00, 8'h00};
   endtask : do_reset

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      {rstn, ce, wr_stb, rd_stb, ack_valid, ack_pending} = 6'b010000;
      addr  = 8'h00;
      wdata = 8'h00;
      void'($urandom(54));
      do_reset();
      read_all();
      repeat (3) begin
         for (int a = 19; a <= 27; a++) wr(8'(a), 8'($urandom) & WM[a]);
         read_all();
      end
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'h13, 8'ha5);
      ce <= 1'b1;
      rd(8'h13);
      ack_rx(1'b1);
      ack_rx(1'b0);
      wr(8'h14, 8'h04);
      wr(8'h15, 8'h06);
      wr(8'h16, 8'h03);
      wr(8'h17, 8'h02);
      wr(8'h18, 8'h00);
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk_sys);
            #1;
            n++;
         end while (sym !== 1'b1 && n < 2000);
      end
      check(8'(n), 8'd8, "symbol gap");
      wr(8'h1b, 8'h0e);
      rd(8'h1b);
      check({7'h00, busy}, 8'h00, "no start");
      wr(8'h1b, 8'h0f);
      #1;
      check({2'b00, busy, amp_on, f_bcn, f_ind, f_ack, f_sec}, 8'h37, "normal go");
      wr(8'h1a, 8'h03);
      wait_start(2, 7, 3);
      check({4'h0, f_bcn, f_ind, f_ack, f_sec}, 8'h07, "held");
      rd(8'h1b);
      rd(8'h1a);
      wr(8'h1b, 8'h0e);
      wr(8'h1b, 8'h01);
      #1;
      check({4'h0, busy, f_ind, f_ack, f_sec}, 8'h08, "no options");
      wait_start(0, 7, 3);
      rd(8'h1b);
      wr(8'h17, 8'h04);
      wr(8'h1a, 8'h03);
      #1;
      check({5'h00, busy, f_bcn, f_sec}, 8'h07, "beacon go");
      wait_start(0, 11, 3);
      rd(8'h1a);
      do_reset();
      read_all();
      tally_and_finish();
   end
endmodule : testbench

bind mtr_regs mtr_regs_chk #(.ADDR_W(ADDR_W)) i_chk (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .ACK_RX_VALID(ACK_RX_VALID), .ACK_RX_PENDING(ACK_RX_PENDING),
   .FIRST_SLOT_END(FIRST_SLOT_END), .CONTENTION_PERIOD_END(CONTENTION_PERIOD_END),
   .SYMBOL_STROBE(SYMBOL_STROBE), .BUSY(BUSY), .TX_ON(TX_ON), .AMP_ON(AMP_ON),
   .FRAME_START(FRAME_START), .FRAME_IS_BEACON(FRAME_IS_BEACON),
   .FRAME_SECURITY(FRAME_SECURITY), .FRAME_ACK_REQUEST(FRAME_ACK_REQUEST),
   .FRAME_INDIRECT(FRAME_INDIRECT)
);
